/* verilog/lcd_instr_defines.vh */
// Constants for the character display instruction decoder.
`ifndef LCD_INSTR_DEFINES_VH
`define LCD_INSTR_DEFINES_VH
// =====================================================================
// Codes and addresses
`define SPACE_CODE        8'h20
`define TEXT_RAM_WORDS    128
`define GLYPH_RAM_WORDS   64
`define LINE1_LAST        7'h27
`define LINE2_FIRST       7'h40
`define LINE2_LAST        7'h67
`define ONE_LINE_LAST     7'h4f
`define DISP_WIDTH        7'h28
// =====================================================================
// Timing at the nominal oscillator, in nanoseconds and cycles
`define CLK_PERIOD_NS     10
`define T_LONG_NS         760000
`define T_SHORT_NS        18500
`define T_BLINK_NS        185000000
`define CYC_LONG          ((`T_LONG_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_SHORT         ((`T_SHORT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_BLINK         (`T_BLINK_NS / `CLK_PERIOD_NS)
// =====================================================================
// Reset values
`define RST_ENTRY_INC     1'b1
`define RST_BUS_WIDTH     1'b1
`endif

/* verilog/busy_timer.v */
// Down counter that holds the busy indicator for an execution time.
`timescale 1ns/1ns
module busy_timer #(
	parameter WIDTH = 20
) (
	// Clock and reset
	input  wire             clock,
	input  wire             rstn,
	input  wire             clk_en,
	// Control
	input  wire             start,
	input  wire [WIDTH-1:0] cycles,
	output wire             busy
);
	reg [WIDTH-1:0] count_ff;
	assign busy = (count_ff != {WIDTH{1'b0}});
	always @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			count_ff <= {WIDTH{1'b0}};
		else if (clk_en)
		begin
			if (start)
				count_ff <= cycles;
			else if (busy)
				count_ff <= count_ff - {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end
endmodule // busy_timer

/* verilog/blink_gen.v */
// Free running blink phase generator.
`timescale 1ns/1ns
module blink_gen #(
	parameter PERIOD = 18500000
) (
	// Clock and reset
	input  wire clock,
	input  wire rstn,
	input  wire clk_en,
	// Phase
	output reg  phase_ff
);
	reg [31:0] count_ff;
	always @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			count_ff <= 32'h00000000;
			phase_ff <= 1'b0;
		end
		else if (clk_en)
		begin
			if (count_ff >= PERIOD - 1)
			begin
				count_ff <= 32'h00000000;
				phase_ff <= ~phase_ff;
			end
			else
				count_ff <= count_ff + 32'h00000001;
		end
	end
endmodule // blink_gen

/* verilog/char_lcd_instruction_decoder.v */
// Instruction decoder and executor of the character display controller.
`timescale 1ns/1ns
`include "lcd_instr_defines.vh"
module char_lcd_instruction_decoder #(
	parameter LONG_CYCLES  = `CYC_LONG,
	parameter SHORT_CYCLES = `CYC_SHORT,
	parameter BLINK_CYCLES = `CYC_BLINK
) (
	// Clock and reset
	input  wire       clock,
	input  wire       rstn,
	input  wire       clk_en,
	// Host transfer, one decoded byte per strobe
	input  wire       xfer_valid,
	input  wire       reg_select,
	input  wire       read_write,
	input  wire [7:0] xfer_data,
	output reg  [7:0] read_data_ff,
	output wire       busy_indicator,
	// Display state
	output reg  [6:0] address_counter,
	output reg        glyph_select_ff,
	output reg        entry_inc_ff,
	output reg        entry_shift_ff,
	output reg        display_on_ff,
	output reg        cursor_on_ff,
	output reg        blink_on_ff,
	output reg        bus_width_select,
	output reg        two_line_ff,
	output reg        font_tall_ff,
	output wire       glyph_tall,
	output reg  [6:0] disp_offset_ff,
	output wire       cursor_lit,
	output wire       clearing,
	// Scan-out read port of text RAM
	input  wire [6:0] scan_addr,
	output reg  [7:0] scan_data_ff
);
	// =====================================================================
	// Storage and state
	localparam ST_IDLE  = 1'b0;
	localparam ST_CLEAR = 1'b1;
	reg [7:0] text_ram  [0:`TEXT_RAM_WORDS-1];
	reg [7:0] glyph_ram [0:`GLYPH_RAM_WORDS-1];
	reg       state_ff;
	reg [6:0] clr_addr_ff;
	localparam TMR_WIDTH = 20;
	reg                 tmr_start;
	reg [TMR_WIDTH-1:0] tmr_cycles;
	wire                tmr_busy;
	wire                blink_phase;
	wire                status_rd;
	wire                accept;
	// Status reads bypass the busy gate so the host can always poll.
	assign status_rd = xfer_valid & ~reg_select & read_write;
	assign accept    = xfer_valid & ~busy_indicator & ~status_rd;
	// The fill walk counts as busy too, so a long count set below the RAM
	// depth cannot let a host write race the walk.
	assign busy_indicator = tmr_busy | clearing;
	assign clearing = (state_ff == ST_CLEAR);
	assign glyph_tall = font_tall_ff & ~two_line_ff;
	// =====================================================================
	// Address step with line wrap
	// Addresses in the gap between the two lines step plainly.
	function [6:0] step_addr;
		input [6:0] a;
		input       up;
		input       two;
		begin
			if (two)
			begin
				if (up)
					step_addr = (a == `LINE1_LAST) ? `LINE2_FIRST :
						(a == `LINE2_LAST) ? 7'h00 : a + 7'h01;
				else
					step_addr = (a == 7'h00) ? `LINE2_LAST :
						(a == `LINE2_FIRST) ? `LINE1_LAST : a - 7'h01;
			end
			else if (up)
				step_addr = (a == `ONE_LINE_LAST) ? 7'h00 : a + 7'h01;
			else
				step_addr = (a == 7'h00) ? `ONE_LINE_LAST : a - 7'h01;
		end
	endfunction
	// The offset wraps at one line's width so all lines move together.
	function [6:0] step_offset;
		input [6:0] o;
		input       left;
		input       two;
		reg   [6:0] last;
		begin
			last = two ? (`DISP_WIDTH - 7'h01) : `ONE_LINE_LAST;
			if (left)
				step_offset = (o == last) ? 7'h00 : o + 7'h01;
			else
				step_offset = (o == 7'h00) ? last : o - 7'h01;
		end
	endfunction
	// Glyph addresses wrap inside six bits; text ones follow the lines.
	function [6:0] step_any;
		input [6:0] a;
		input       up;
		input       two;
		input       glyph;
		begin
			if (glyph)
				step_any = {1'b0, up ? a[5:0] + 6'h01 : a[5:0] - 6'h01};
			else
				step_any = step_addr(a, up, two);
		end
	endfunction
	// Clear and return home share the long execution time.
	function long_op;
		input [7:0] d;
		begin
			long_op = (d[7:2] == 6'h00);
		end
	endfunction
	// =====================================================================
	// Helpers
	busy_timer #(
		.WIDTH (TMR_WIDTH)
	) u_busy (
		.clock  (clock),
		.rstn   (rstn),
		.clk_en (clk_en),
		.start  (tmr_start),
		.cycles (tmr_cycles),
		.busy   (tmr_busy)
	);
	blink_gen #(
		.PERIOD (BLINK_CYCLES)
	) u_blink (
		.clock    (clock),
		.rstn     (rstn),
		.clk_en   (clk_en),
		.phase_ff (blink_phase)
	);
	// Cursor cell lights solid, or alternates with the stored glyph.
	assign cursor_lit = display_on_ff & cursor_on_ff & (~blink_on_ff | blink_phase);
	// =====================================================================
	// Timer start on every accepted operation
	always @*
	begin
		tmr_start = 1'b0;
		tmr_cycles = SHORT_CYCLES[TMR_WIDTH-1:0];
		if (accept)
		begin
			tmr_start = 1'b1;
			if (!reg_select && long_op(xfer_data))
				tmr_cycles = LONG_CYCLES[TMR_WIDTH-1:0];
		end
	end
	// =====================================================================
	// RAM ports; clear walks text RAM one word a cycle while busy.
	// Text RAM has no reset value; a clear is needed before first use.
	always @(posedge clock)
	begin
		if (clk_en)
		begin
			scan_data_ff <= text_ram[scan_addr];
			if (state_ff == ST_CLEAR)
				text_ram[clr_addr_ff] <= `SPACE_CODE;
			else if (accept && reg_select && !read_write && !glyph_select_ff)
				text_ram[address_counter] <= xfer_data;
			if (accept && reg_select && !read_write && glyph_select_ff)
				glyph_ram[address_counter[5:0]] <= xfer_data;
		end
	end
	// =====================================================================
	// Instruction execution
	always @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			state_ff         <= ST_IDLE;
			clr_addr_ff      <= 7'h00;
			address_counter  <= 7'h00;
			glyph_select_ff  <= 1'b0;
			entry_inc_ff     <= `RST_ENTRY_INC;
			entry_shift_ff   <= 1'b0;
			display_on_ff    <= 1'b0;
			cursor_on_ff     <= 1'b0;
			blink_on_ff      <= 1'b0;
			bus_width_select <= `RST_BUS_WIDTH;
			two_line_ff      <= 1'b0;
			font_tall_ff     <= 1'b0;
			disp_offset_ff   <= 7'h00;
			read_data_ff     <= 8'h00;
		end
		else if (clk_en)
		begin
			// The fill walk runs on its own once started.
			case (state_ff)
				ST_IDLE:
					clr_addr_ff <= 7'h00;
				ST_CLEAR:
				begin
					clr_addr_ff <= clr_addr_ff + 7'h01;
					if (clr_addr_ff == 7'h7f)
						state_ff <= ST_IDLE;
				end
				default:
					state_ff <= ST_IDLE;
			endcase
			// Status read is never blocked so the host can poll.
			if (status_rd)
				read_data_ff <= {busy_indicator, address_counter};
			if (accept)
			begin
				if (reg_select)
				begin
					// Glyph addresses step in six bits; text ones follow lines.
					if (read_write)
						read_data_ff <= glyph_select_ff ?
							glyph_ram[address_counter[5:0]] : text_ram[address_counter];
					address_counter <= step_any(address_counter, entry_inc_ff,
						two_line_ff, glyph_select_ff);
					if (!read_write && !glyph_select_ff && entry_shift_ff)
						disp_offset_ff <= step_offset(disp_offset_ff, entry_inc_ff,
							two_line_ff);
				end
				else if (xfer_data[7])
				begin
					address_counter <= xfer_data[6:0];
					glyph_select_ff <= 1'b0;
				end
				else if (xfer_data[6])
				begin
					address_counter <= {1'b0, xfer_data[5:0]};
					glyph_select_ff <= 1'b1;
				end
				else if (xfer_data[5])
				begin
					bus_width_select <= xfer_data[4];
					two_line_ff      <= xfer_data[3];
					font_tall_ff     <= xfer_data[2];
				end
				else if (xfer_data[4])
				begin
					if (xfer_data[3])
						disp_offset_ff <= step_offset(disp_offset_ff, ~xfer_data[2],
							two_line_ff);
					else
						address_counter <= step_any(address_counter, xfer_data[2],
							two_line_ff, glyph_select_ff);
				end
				else if (xfer_data[3])
				begin
					display_on_ff <= xfer_data[2];
					cursor_on_ff  <= xfer_data[1];
					blink_on_ff   <= xfer_data[0];
				end
				else if (xfer_data[2])
				begin
					entry_inc_ff   <= xfer_data[1];
					entry_shift_ff <= xfer_data[0];
				end
				else if (xfer_data[1])
				begin
					address_counter <= 7'h00;
					glyph_select_ff <= 1'b0;
					disp_offset_ff  <= 7'h00;
				end
				// Counter and flags settle at once; the fill walk follows.
				else if (xfer_data[0])
				begin
					address_counter <= 7'h00;
					glyph_select_ff <= 1'b0;
					disp_offset_ff  <= 7'h00;
					entry_inc_ff    <= 1'b1;
					state_ff        <= ST_CLEAR;
					clr_addr_ff     <= 7'h00;
				end
			end
		end
	end
endmodule // char_lcd_instruction_decoder

/* tb/lcd_host.sv */
// Host model that issues bytes and polls the busy flag.
`timescale 1ns/1ns
module lcd_host (
	// Clock
	input  wire logic       clock,
	// Host transfer
	output logic            xfer_valid,
	output logic            reg_select,
	output logic            read_write,
	output logic      [7:0] xfer_data,
	input  wire logic [7:0] read_data_ff,
	output logic            hung
);
	initial
	begin
		xfer_valid = 1'b0;
		reg_select = 1'b0;
		read_write = 1'b0;
		xfer_data = 8'h00;
		hung = 1'b0;
	end
	// =====
	// One strobe; the idle bus shows the inverse so stale data cannot pass.
	task automatic put(input logic r, input logic w, input logic [7:0] d);
		@(negedge clock);
		xfer_valid = 1'b1;
		reg_select = r;
		read_write = w;
		xfer_data = d;
		@(negedge clock);
		xfer_valid = 1'b0;
		xfer_data = ~d;
	endtask
	task automatic cmd(input logic r, input logic w, input logic [7:0] d);
		int n;
		n = 0;
		put(1'b0, 1'b1, 8'h00);
		while (read_data_ff[7] !== 1'b0 && n < 400)
		begin
			put(1'b0, 1'b1, 8'h00);
			n++;
		end
		if (n >= 400)
			hung = 1'b1;
		put(r, w, d);
	endtask
endmodule // lcd_host

/* tb/char_lcd_instruction_decoder_monitor.sv */
// Checker for the instruction decoder ports.
`timescale 1ns/1ns
module char_lcd_instruction_decoder_monitor (
	// Clock and reset
	input wire logic       clock,
	input wire logic       rstn,
	input wire logic       clk_en,
	// Host transfer
	input wire logic       xfer_valid,
	input wire logic       reg_select,
	input wire logic       read_write,
	input wire logic [7:0] xfer_data,
	input wire logic [7:0] read_data_ff,
	input wire logic       busy_indicator,
	// Display state
	input wire logic [6:0] address_counter,
	input wire logic       glyph_select_ff,
	input wire logic       entry_inc_ff,
	input wire logic       entry_shift_ff,
	input wire logic       display_on_ff,
	input wire logic       cursor_on_ff,
	input wire logic       blink_on_ff,
	input wire logic       bus_width_select,
	input wire logic       two_line_ff,
	input wire logic       font_tall_ff,
	input wire logic       glyph_tall,
	input wire logic [6:0] disp_offset_ff,
	input wire logic       clearing
);
	wire ins = clk_en && xfer_valid && !busy_indicator && !reg_select && !read_write;
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	// =====
	// Busy is checked only for eight cycles; the bench measures the full length.
	chk_clear_effect: assert property (
		ins && xfer_data == 8'h01 |=> busy_indicator [*8] ##0 address_counter == 7'h00
		&& entry_inc_ff && clearing) else $error("clear effect wrong");
	chk_home_zero: assert property (
		ins && xfer_data[7:1] == 7'h01 |=> address_counter == 7'h00 && disp_offset_ff == 7'h00)
		else $error("home wrong");
	chk_entry_flags: assert property (
		ins && xfer_data[7:2] == 6'h01 |=> {entry_inc_ff, entry_shift_ff} == $past(xfer_data[1:0]))
		else $error("entry flags wrong");
	chk_ctrl_latch: assert property (
		ins && xfer_data[7:3] == 5'h01 |=> {display_on_ff, cursor_on_ff, blink_on_ff}
		== $past(xfer_data[2:0])) else $error("display control wrong");
	chk_func_latch: assert property (
		ins && xfer_data[7:5] == 3'h1 |=> {bus_width_select, two_line_ff, font_tall_ff}
		== $past(xfer_data[4:2])) else $error("function set wrong");
	chk_text_addr: assert property (
		ins && xfer_data[7] |=> address_counter == $past(xfer_data[6:0]) && !glyph_select_ff)
		else $error("text address wrong");
	chk_glyph_addr: assert property (
		ins && xfer_data[7:6] == 2'h1 |=> address_counter[5:0] == $past(xfer_data[5:0])
		&& glyph_select_ff) else $error("glyph address wrong");
	chk_status_read: assert property (
		clk_en && xfer_valid && !reg_select && read_write |=> read_data_ff
		== {$past(busy_indicator), $past(address_counter)}) else $error("status wrong");
	chk_font_height: assert property (
		glyph_tall == (font_tall_ff && !two_line_ff)) else $error("glyph height wrong");
endmodule // char_lcd_instruction_decoder_monitor
bind char_lcd_instruction_decoder char_lcd_instruction_decoder_monitor mon_u (.*);

/* tb/char_lcd_instruction_decoder_test.sv */
// Testbench for the instruction decoder.
`timescale 1ns/1ns
module char_lcd_instruction_decoder_test;
	logic       clock = 1'b0;
	logic       rstn = 1'b0;
	logic       clk_en = 1'b1;
	logic       xfer_valid, reg_select, read_write, hung;
	logic [7:0] xfer_data, read_data_ff, scan_data_ff;
	logic [6:0] address_counter, disp_offset_ff;
	logic [6:0] scan_addr = 7'h00;
	logic       busy_indicator, glyph_select_ff, entry_inc_ff, entry_shift_ff;
	logic       display_on_ff, cursor_on_ff, blink_on_ff, bus_width_select;
	logic       two_line_ff, font_tall_ff, glyph_tall, cursor_lit, clearing;
	int         fails = 0;
	int         comparisons = 0;
	// =====
	// Short counts keep the run brief; every expectation uses them.
	char_lcd_instruction_decoder #(.LONG_CYCLES(200), .SHORT_CYCLES(20), .BLINK_CYCLES(50))
		dut_u (.*);
	lcd_host host_u (.*);
	always #5 clock = ~clock;
	// =====
	task miss(input string msg);
		fails++;
		$display("CHECK FAILED %0t %s", $time, msg);
	endtask
	task summarize;
		if (fails == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task run(input logic [1:0] k, input logic [7:0] d);
		host_u.cmd(k[1], k[0], d);
		if (hung)
		begin
			miss("busy poll timed out");
			summarize();
		end
	endtask
	task dur(input int len);
		int n;
		n = 0;
		while (busy_indicator === 1'b1 && n < 1000)
		begin
			@(negedge clock);
			n++;
		end
		if (n >= 1000)
		begin
			miss("busy never fell");
			summarize();
		end
		comparisons++;
		if (n < len - 1 || n > len + 1) miss("busy length wrong");
	endtask
	// =====
	task t_clear;
		run(2'h0, 8'h85);
		run(2'h2, 8'h41);
		run(2'h0, 8'h04);
		run(2'h0, 8'h01);
		comparisons++;
		if (clearing !== 1'b1) miss("clear walk not started");
		dur(200);
		scan_addr = 7'h05;
		@(negedge clock);
		comparisons++;
		if (scan_data_ff !== 8'h20) miss("text not cleared");
		comparisons++;
		if (address_counter !== 7'h00) miss("counter not zeroed by clear");
		comparisons++;
		if (entry_inc_ff !== 1'b1) miss("direction not forced up");
	endtask
	task t_step;
		run(2'h0, 8'h90);
		run(2'h0, 8'h07);
		run(2'h2, 8'h5a);
		comparisons++;
		if (address_counter !== 7'h11) miss("write did not step up");
		comparisons++;
		if (disp_offset_ff !== 7'h01) miss("write did not shift left");
		dur(20);
		run(2'h0, 8'h90);
		run(2'h0, 8'h05);
		run(2'h3, 8'h00);
		comparisons++;
		if (read_data_ff !== 8'h5a) miss("text read data wrong");
		comparisons++;
		if (address_counter !== 7'h0f) miss("read did not step down");
		comparisons++;
		if (disp_offset_ff !== 7'h01) miss("read shifted the display");
		run(2'h2, 8'h33);
		comparisons++;
		if (address_counter !== 7'h0e) miss("write did not step down");
		comparisons++;
		if (disp_offset_ff !== 7'h00) miss("write did not shift right");
	endtask
	task t_shift;
		run(2'h0, 8'h38);
		run(2'h0, 8'ha7);
		run(2'h0, 8'h10);
		comparisons++;
		if (address_counter !== 7'h26) miss("cursor left shift wrong");
		run(2'h0, 8'h14);
		run(2'h0, 8'h14);
		comparisons++;
		if (address_counter !== 7'h40) miss("no wrap to second line");
		run(2'h0, 8'h18);
		comparisons++;
		if (address_counter !== 7'h40) miss("display shift moved counter");
		comparisons++;
		if (disp_offset_ff !== 7'h01) miss("display shift wrong");
		run(2'h0, 8'h02);
		comparisons++;
		if (address_counter !== 7'h00) miss("home counter wrong");
		comparisons++;
		if (disp_offset_ff !== 7'h00) miss("home kept the shift");
	endtask
	task t_glyph;
		run(2'h0, 8'h07);
		run(2'h0, 8'h45);
		run(2'h2, 8'h1f);
		comparisons++;
		if (glyph_select_ff !== 1'b1) miss("glyph RAM not selected");
		comparisons++;
		if (address_counter !== 7'h06) miss("glyph write did not step");
		comparisons++;
		if (disp_offset_ff !== 7'h00) miss("glyph write shifted display");
		run(2'h0, 8'h45);
		run(2'h3, 8'h00);
		comparisons++;
		if (read_data_ff !== 8'h1f) miss("glyph read data wrong");
		comparisons++;
		if (address_counter !== 7'h06) miss("glyph read did not step");
	endtask
	task t_ctrl;
		int   n;
		logic prev;
		run(2'h0, 8'h0f);
		n = 0;
		prev = cursor_lit;
		repeat (120)
		begin
			@(negedge clock);
			if (cursor_lit !== prev)
				n++;
			prev = cursor_lit;
		end
		comparisons++;
		if (n < 2 || n > 3) miss("cursor does not blink");
		run(2'h0, 8'h0e);
		comparisons++;
		if (cursor_lit !== 1'b1) miss("steady cursor not lit");
		run(2'h0, 8'h05);
		run(2'h0, 8'h0c);
		comparisons++;
		if (cursor_lit !== 1'b0) miss("cursor still lit");
		comparisons++;
		if (entry_inc_ff !== 1'b0) miss("cursor off changed direction");
		run(2'h0, 8'h0a);
		comparisons++;
		if (display_on_ff !== 1'b0) miss("display not turned off");
		comparisons++;
		if (cursor_lit !== 1'b0) miss("cursor lit on blank panel");
		run(2'h0, 8'h27);
		comparisons++;
		if (bus_width_select !== 1'b0) miss("bus width not latched");
		comparisons++;
		if (glyph_tall !== 1'b1) miss("tall glyphs not selected");
	endtask
	task t_refuse;
		run(2'h0, 8'h01);
		host_u.put(1'b0, 1'b0, 8'h90);
		run(2'h1, 8'h00);
		comparisons++;
		if (address_counter !== 7'h00) miss("write taken while busy");
		comparisons++;
		if (read_data_ff !== 8'h00) miss("status read wrong");
	endtask
	task t_freeze;
		run(2'h0, 8'h06);
		clk_en = 1'b0;
		repeat (10) @(negedge clock);
		comparisons++;
		if (busy_indicator !== 1'b1) miss("busy lost while frozen");
		clk_en = 1'b1;
		dur(20);
	endtask
	initial
	begin
		repeat (16) @(negedge clock);
		rstn = 1'b1;
		t_clear();
		t_step();
		t_shift();
		t_glyph();
		t_ctrl();
		t_refuse();
		t_freeze();
		summarize();
	end
endmodule // char_lcd_instruction_decoder_test
